// ===== verilog/pll_status_latch_bank.sv
/*
  Status register bank: momentary PLL and input status, sticky latches,
  interrupt enables and the active-low interrupt output.
  Assumes a serial configuration engine presents byte accesses on the
  reg_* ports, one-cycle strobes on ref_clk_in.
*/
// What this block does
// - VCXO lock latch reads 0 after loss
// - Write 1 clears VCXO latch and interrupt
// - Input loss latches read 0 after loss
// - Write 1 clears input latch and interrupt
// - Two-bit field reports selected reference input
// - Synth momentary lock bit, 0 on loss
// - VCXO momentary lock bit, 0 on loss
// - Input momentary bit, 0 on signal loss
// - Reference latch reads 0 after reference lost
// - Write 1 clears reference latch and interrupt
// - Enabled latched fault on sources 0 to 5 drives interrupt low
// - Reference interrupt when its latch sets on a loss; a clear withdraws it
// - Reference present bit reads 1 when present
`timescale 1ns/1ps
module pll_status_latch_bank
  import status_bank_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [3:0] input_signal_active_in,
  input  wire logic       synth_loop_lock_in,
  input  wire logic       vcxo_loop_lock_in,
  input  wire logic       reference_present_in,
  input  wire logic [1:0] selected_input_in,
  input  wire logic [7:0] reg_addr_in,
  input  wire logic       reg_wr_in,
  input  wire logic       reg_rd_in,
  input  wire logic [7:0] reg_wdata_in,
  output logic      [7:0] reg_rdata_out,
  output logic            interrupt_out_low
);

  // ************************************************************
  // Synchronised momentary status
  // ************************************************************
  logic [6:0] raw_status;
  logic [6:0] sync_status;
  momentary_t now;
  reg_req_t   req;

  assign raw_status = {reference_present_in, synth_loop_lock_in,
                       vcxo_loop_lock_in, input_signal_active_in};
  assign req        = '{addr: reg_addr_in, wr: reg_wr_in, rd: reg_rd_in,
                        wdata: reg_wdata_in};

  status_input_sync u_sync (
    .ref_clk_in (ref_clk_in),
    .reset_n_in (reset_n_in),
    .raw_in     (raw_status),
    .stable_out (sync_status)
  );

  // Bits are active-high "good"; a 0 means the fault is present now.
  assign now = momentary_t'(sync_status);

  // ************************************************************
  // Address decode
  // ************************************************************
  function automatic logic hit(input reg_req_t r, input logic [7:0] a);
    hit = r.wr && (r.addr == a);
  endfunction : hit

  logic [6:0] clear_vec;
  logic       wr_en_lo;
  logic       wr_en_hi;

  always_comb begin
    clear_vec = 7'h00;
    if (hit(req, loss_sticky_addr)) begin
      clear_vec[3:0]       = req.wdata[input_lsb_pos +: 4];
      clear_vec[src_vcxo]  = req.wdata[vcxo_bit_pos];
      clear_vec[src_synth] = req.wdata[synth_bit_pos];
    end
    if (hit(req, ref_sticky_addr)) begin
      clear_vec[src_ref] = req.wdata[ref_latch_pos];
    end
  end

  assign wr_en_lo = hit(req, irq_enable_lo_addr);
  assign wr_en_hi = hit(req, irq_enable_hi_addr);

  // ************************************************************
  // Sticky latches
  // ************************************************************
  logic [6:0] fault;
  logic [6:0] set_event;

  genvar g;
  generate
    for (g = 0; g < src_count; g++) begin : g_latch
      fault_latch u_latch (
        .ref_clk_in    (ref_clk_in),
        .reset_n_in    (reset_n_in),
        .fault_now_in  (~sync_status[g]),
        .clear_in      (clear_vec[g]),
        .fault_out     (fault[g]),
        .set_event_out (set_event[g])
      );
    end
  endgenerate

  // ************************************************************
  // Interrupt enables and reference change pending
  // ************************************************************
  logic [6:0] enable_r;
  logic [6:0] enable_nxt;
  logic       ref_pend_r;
  logic       ref_pend_nxt;
  logic       irq_r;
  logic       irq_nxt;

  always_comb begin
    enable_nxt = enable_r;
    if (wr_en_lo) begin
      enable_nxt[5:0] = req.wdata[5:0];
    end
    if (wr_en_hi) begin
      enable_nxt[src_ref] = req.wdata[ref_enable_pos];
    end
  end

  // The latched reference bit only changes by a new loss or by a clear;
  // the clear withdraws the request, so a change by loss raises it.
  always_comb begin
    if (set_event[src_ref]) begin
      ref_pend_nxt = 1'b1;
    end else if (clear_vec[src_ref]) begin
      ref_pend_nxt = 1'b0;
    end else begin
      ref_pend_nxt = ref_pend_r;
    end
  end

  // Mirrors the latches' next state so the pin flop changes on the same edge as the latches.
  // A fault on sources 0 to 5 still present during a clear keeps its latch set, so it keeps the pin low.
  function automatic logic [5:0] fault_nxt_view(input logic [6:0] f,
                                                input logic [6:0] s,
                                                input logic [6:0] c);
    fault_nxt_view = (f[5:0] & ~c[5:0]) | s[5:0];
  endfunction : fault_nxt_view

  // A disabled source never pulls the line, even with its latch set.
  always_comb begin
    irq_nxt = ~(|(fault_nxt_view(fault, ~sync_status, clear_vec) & enable_r[5:0])
                | (ref_pend_nxt & enable_r[src_ref]));
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      enable_r   <= enable_reset_val;
      ref_pend_r <= fault_reset_val;
      irq_r      <= irq_idle_level;
    end else begin
      enable_r   <= enable_nxt;
      ref_pend_r <= ref_pend_nxt;
      irq_r      <= irq_nxt;
    end
  end

  assign interrupt_out_low = irq_r;

  // ************************************************************
  // Read data
  // ************************************************************
  logic [7:0] rdata_r;
  logic [7:0] rdata_nxt;
  logic [7:0] rd_mux;

  always_comb begin
    case (req.addr)
      irq_enable_lo_addr: rd_mux = {2'b00, enable_r[5:0]};
      irq_enable_hi_addr: rd_mux = {6'h00, enable_r[src_ref], 1'b0};
      loss_sticky_addr:   rd_mux = {2'b00, ~fault[5:0]};
      status_now_addr:    rd_mux = {selected_input_in, now.synth_loop_lock_now,
                                    now.vcxo_loop_lock_now,
                                    now.input_signal_active_now};
      ref_sticky_addr:    rd_mux = {6'h00, ~fault[src_ref], 1'b0};
      ref_now_addr:       rd_mux = {6'h00, now.reference_present_now, 1'b0};
      default:            rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    rdata_nxt = req.rd ? rd_mux : rdata_r;
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      rdata_r <= rdata_reset_val;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata_out = rdata_r;

endmodule : pll_status_latch_bank

// ===== verilog/status_bank_pkg.sv
/*
  Constants and carrier types for the status latch bank.
  Assumes a byte-wide register port from the serial configuration engine.
*/
package status_bank_pkg;

  // ************************************************************
  // Register offsets
  // ************************************************************
  localparam logic [7:0] irq_enable_lo_addr = 8'h68;
  localparam logic [7:0] irq_enable_hi_addr = 8'h69;
  localparam logic [7:0] loss_sticky_addr   = 8'h6C;
  localparam logic [7:0] status_now_addr    = 8'h6D;
  localparam logic [7:0] ref_sticky_addr    = 8'h6E;
  localparam logic [7:0] ref_now_addr       = 8'h6F;

  // ************************************************************
  // Field positions
  // ************************************************************
  localparam int input_lsb_pos    = 0;
  localparam int vcxo_bit_pos     = 4;
  localparam int synth_bit_pos    = 5;
  localparam int sel_lsb_pos      = 6;
  localparam int ref_latch_pos    = 1;
  localparam int ref_now_pos      = 1;
  localparam int ref_enable_pos   = 1;

  // Source index inside the seven-wide fault vector.
  localparam int src_count        = 7;
  localparam int src_vcxo         = 4;
  localparam int src_synth        = 5;
  localparam int src_ref          = 6;

  // ************************************************************
  // Reset values
  // ************************************************************
  localparam logic [6:0] enable_reset_val  = 7'h00;
  localparam logic [6:0] momentary_idle    = 7'h7F;
  localparam logic       fault_reset_val   = 1'b0;
  localparam logic [7:0] rdata_reset_val   = 8'h00;
  localparam logic       irq_idle_level    = 1'b1;

  // ************************************************************
  // Carrier types
  // ************************************************************
  typedef struct packed {
    logic       reference_present_now;
    logic       synth_loop_lock_now;
    logic       vcxo_loop_lock_now;
    logic [3:0] input_signal_active_now;
  } momentary_t;

  typedef struct packed {
    logic [7:0] addr;
    logic       wr;
    logic       rd;
    logic [7:0] wdata;
  } reg_req_t;

endpackage : status_bank_pkg

// ===== verilog/status_input_sync.sv
/*
  Three-stage synchroniser for the momentary status inputs.
  Assumes the inputs come from detectors outside the clock domain.
*/
`timescale 1ns/1ps
module status_input_sync
  import status_bank_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       reset_n_in,
  input  wire logic [6:0] raw_in,
  output logic      [6:0] stable_out
);

  logic [6:0] stage1_r;
  logic [6:0] stage2_r;
  logic [6:0] stage3_r;
  logic [6:0] held_r;
  logic [6:0] held_nxt;

  // A bit counts only once the last two stages agree, filtering one-cycle glitches.
  always_comb begin
    for (int i = 0; i < src_count; i++) begin
      held_nxt[i] = (stage2_r[i] == stage3_r[i]) ? stage3_r[i] : held_r[i];
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      stage1_r <= momentary_idle;
      stage2_r <= momentary_idle;
      stage3_r <= momentary_idle;
      held_r   <= momentary_idle;
    end else begin
      stage1_r <= raw_in;
      stage2_r <= stage1_r;
      stage3_r <= stage2_r;
      held_r   <= held_nxt;
    end
  end

  assign stable_out = held_r;

endmodule : status_input_sync

// ===== verilog/fault_latch.sv
/*
  One sticky fault latch with write-one-to-clear.
  Assumes the fault condition is already synchronised to ref_clk_in.
*/
`timescale 1ns/1ps
module fault_latch
  import status_bank_pkg::*;
(
  input  wire logic ref_clk_in,
  input  wire logic reset_n_in,
  input  wire logic fault_now_in,
  input  wire logic clear_in,
  output logic      fault_out,
  output logic      set_event_out
);

  logic fault_r;
  logic fault_nxt;

  // A fault in the clear cycle wins so the event is never lost.
  always_comb begin
    if (fault_now_in) begin
      fault_nxt = 1'b1;
    end else if (clear_in) begin
      fault_nxt = 1'b0;
    end else begin
      fault_nxt = fault_r;
    end
  end

  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      fault_r <= fault_reset_val;
    end else begin
      fault_r <= fault_nxt;
    end
  end

  assign fault_out     = fault_r;
  assign set_event_out = fault_nxt & ~fault_r;

endmodule : fault_latch

// ===== testbench/pll_status_latch_bank_props.sv
/*
  Port checker for the status latch bank, attached by the bind at the foot.
  Assumes status inputs held for six cycles have crossed the synchroniser.
*/
`timescale 1ns/1ps
module pll_status_latch_bank_props
  import status_bank_pkg::*;
(
  input wire logic       ref_clk_in,
  input wire logic       reset_n_in,
  input wire logic [3:0] input_signal_active_in,
  input wire logic       synth_loop_lock_in,
  input wire logic       vcxo_loop_lock_in,
  input wire logic       reference_present_in,
  input wire logic [1:0] selected_input_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic       reg_wr_in,
  input wire logic       reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  input wire logic [7:0] reg_rdata_out,
  input wire logic       interrupt_out_low
);
  // ************************************************************
  // Helper logic
  // ************************************************************
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!reset_n_in);
  logic [7:0] en_r;
  logic [7:0] en_nxt;
  wire        rd_now  = reg_rd_in && reg_addr_in == status_now_addr;
  wire        rd_loss = reg_rd_in && reg_addr_in == loss_sticky_addr;
  wire        wr_loss = reg_wr_in && reg_addr_in == loss_sticky_addr;
  wire        rd_refs = reg_rd_in && reg_addr_in == ref_sticky_addr;
  wire        rd_refn = reg_rd_in && reg_addr_in == ref_now_addr;
  always_comb begin
    en_nxt = (reg_wr_in && reg_addr_in == irq_enable_lo_addr) ? reg_wdata_in : en_r;
  end
  always_ff @(posedge ref_clk_in or negedge reset_n_in) begin
    if (!reset_n_in) begin
      en_r <= 8'h00;
    end else begin
      en_r <= en_nxt;
    end
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  sequence s_vcxo_clear;
    vcxo_loop_lock_in [*6] ##0 (wr_loss && reg_wdata_in[4]) ##2 (rd_loss && vcxo_loop_lock_in);
  endsequence
  a_sel_field: assert property (rd_now |=> reg_rdata_out[7:6] == $past(selected_input_in))
    else $error("selected input field wrong");
  a_synth_now: assert property ($stable(synth_loop_lock_in) [*6] ##0 rd_now
    |=> reg_rdata_out[5] == $past(synth_loop_lock_in)) else $error("synth lock bit wrong");
  a_vcxo_now: assert property ($stable(vcxo_loop_lock_in) [*6] ##0 rd_now
    |=> reg_rdata_out[4] == $past(vcxo_loop_lock_in)) else $error("vcxo lock bit wrong");
  a_input_now: assert property ($stable(input_signal_active_in) [*6] ##0 rd_now
    |=> reg_rdata_out[3:0] == $past(input_signal_active_in)) else $error("input bits wrong");
  a_ref_now: assert property ($stable(reference_present_in) [*6] ##0 rd_refn
    |=> reg_rdata_out[1] == $past(reference_present_in)) else $error("ref present wrong");
  a_vcxo_sticky: assert property (!vcxo_loop_lock_in [*6] ##0 rd_loss
    |=> !reg_rdata_out[4]) else $error("vcxo latch not set");
  a_input_sticky: assert property (!input_signal_active_in[0] [*6] ##0 rd_loss
    |=> !reg_rdata_out[0]) else $error("input latch not set");
  a_ref_sticky: assert property (!reference_present_in [*6] ##0 rd_refs
    |=> !reg_rdata_out[1]) else $error("ref latch not set");
  a_vcxo_clear: assert property (s_vcxo_clear |=> reg_rdata_out[4])
    else $error("vcxo latch not cleared");
  a_irq_enabled: assert property ((en_r[4] && !vcxo_loop_lock_in) [*6]
    |=> !interrupt_out_low) else $error("enabled fault left interrupt high");
endmodule : pll_status_latch_bank_props

bind pll_status_latch_bank pll_status_latch_bank_props u_props (.ref_clk_in, .reset_n_in,
  .input_signal_active_in, .synth_loop_lock_in, .vcxo_loop_lock_in, .reference_present_in,
  .selected_input_in, .reg_addr_in, .reg_wr_in, .reg_rd_in, .reg_wdata_in, .reg_rdata_out,
  .interrupt_out_low);

// ===== testbench/test_pll_status_latch_bank.sv
/*
  Self-checking bench for the status latch bank through its byte register port.
  Assumes one-cycle strobes and read data valid one cycle after the read.
*/
`timescale 1ns/1ps
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin error_cnt++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, (g), (e)); end end
module test_pll_status_latch_bank
  import status_bank_pkg::*;
;
  // ************************************************************
  // Signals and design
  // ************************************************************
  logic       ref_clk_in = 1'b0;
  logic       reset_n_in = 1'b0;
  logic [3:0] act        = 4'hF;
  logic       synth      = 1'b1;
  logic       vcxo       = 1'b1;
  logic       refp       = 1'b1;
  logic [1:0] sel        = 2'h0;
  logic [7:0] addr       = 8'h00;
  logic       wr         = 1'b0;
  logic       rd         = 1'b0;
  logic [7:0] wdata      = 8'h00;
  logic [7:0] rdata;
  logic       irq_low;
  int         error_cnt    = 0;
  int         total_checks = 0;
  pll_status_latch_bank u_dut (.ref_clk_in(ref_clk_in), .reset_n_in(reset_n_in),
    .input_signal_active_in(act), .synth_loop_lock_in(synth), .vcxo_loop_lock_in(vcxo),
    .reference_present_in(refp), .selected_input_in(sel), .reg_addr_in(addr),
    .reg_wr_in(wr), .reg_rd_in(rd), .reg_wdata_in(wdata), .reg_rdata_out(rdata),
    .interrupt_out_low(irq_low));
  // ************************************************************
  // Tasks
  // ************************************************************
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge ref_clk_in);
    wr <= 1'b0;
    @(posedge ref_clk_in);
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [7:0] e);
    addr <= a;
    rd <= 1'b1;
    @(posedge ref_clk_in);
    rd <= 1'b0;
    @(posedge ref_clk_in);
    `CHK(rdata, e)
  endtask : rd_reg
  // Eight cycles covers the three-flop synchroniser plus the agree stage.
  task automatic settle();
    repeat (8) @(posedge ref_clk_in);
  endtask : settle
  task automatic chk_irq(input logic e);
    `CHK(irq_low, e)
  endtask : chk_irq
  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : complete_run
  // ************************************************************
  // Tests
  // ************************************************************
  initial begin
    forever #10 ref_clk_in = ~ref_clk_in;
  end
  // The tests need about 240 cycles, so this limit only trips on a hang.
  initial begin
    repeat (3000) @(posedge ref_clk_in);
    error_cnt++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge ref_clk_in);
    reset_n_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_reg(loss_sticky_addr, 8'h3F);
    rd_reg(ref_sticky_addr, 8'h02);
    rd_reg(irq_enable_lo_addr, 8'h00);
    rd_reg(8'h70, 8'h00);
    chk_irq(1'b1);
    for (int s = 0; s < 4; s++) begin
      sel <= s[1:0];
      rd_reg(status_now_addr, {s[1:0], 6'h3F});
    end
    $display("test reset and select done");
    vcxo <= 1'b0;
    settle();
    chk_irq(1'b1);
    rd_reg(status_now_addr, 8'hEF);
    wr_reg(irq_enable_lo_addr, 8'h10);
    settle();
    chk_irq(1'b0);
    wr_reg(loss_sticky_addr, 8'h10);
    chk_irq(1'b0);
    rd_reg(loss_sticky_addr, 8'h2F);
    vcxo <= 1'b1;
    settle();
    rd_reg(loss_sticky_addr, 8'h2F);
    wr_reg(loss_sticky_addr, 8'h10);
    chk_irq(1'b1);
    rd_reg(loss_sticky_addr, 8'h3F);
    $display("test vcxo latch done");
    for (int n = 0; n < 4; n++) begin
      wr_reg(irq_enable_lo_addr, {4'h0, 4'h1 << n});
      act[n] <= 1'b0;
      settle();
      rd_reg(status_now_addr, {4'hF, 4'hF & ~(4'h1 << n)});
      rd_reg(loss_sticky_addr, {4'h3, 4'hF & ~(4'h1 << n)});
      act[n] <= 1'b1;
      settle();
      rd_reg(loss_sticky_addr, {4'h3, 4'hF & ~(4'h1 << n)});
      chk_irq(1'b0);
      wr_reg(loss_sticky_addr, {4'h0, 4'h1 << n});
      chk_irq(1'b1);
      rd_reg(loss_sticky_addr, 8'h3F);
    end
    synth <= 1'b0;
    settle();
    rd_reg(status_now_addr, 8'hDF);
    synth <= 1'b1;
    settle();
    wr_reg(loss_sticky_addr, 8'h20);
    $display("test inputs and synth done");
    wr_reg(irq_enable_hi_addr, 8'h02);
    refp <= 1'b0;
    settle();
    rd_reg(ref_now_addr, 8'h00);
    rd_reg(ref_sticky_addr, 8'h00);
    chk_irq(1'b0);
    wr_reg(irq_enable_lo_addr, 8'h10);
    vcxo <= 1'b0;
    settle();
    refp <= 1'b1;
    vcxo <= 1'b1;
    settle();
    rd_reg(ref_now_addr, 8'h02);
    wr_reg(ref_sticky_addr, 8'h02);
    chk_irq(1'b0);
    rd_reg(ref_sticky_addr, 8'h02);
    wr_reg(loss_sticky_addr, 8'h10);
    chk_irq(1'b1);
    $display("test reference done");
    complete_run();
  end
endmodule : test_pll_status_latch_bank
